/* File: core/edc_pkg.sv */
// Shared constants, pin bundle and state codes for the EDO DRAM host controller.
// Assumes a 20 MHz system clock and a 1M x 16 EDO DRAM on the far side.
package edc_pkg;
    // Clock period
    localparam int CLK_NS = 50;
    // Power-up pause, least time, rounded up
    localparam int T_POWER_NS = 200000;
    localparam int POWER_CYC = (T_POWER_NS + CLK_NS - 1) / CLK_NS;
    // Strobe refreshes needed to wake the array
    localparam int WAKE_CYCLES = 8;
    // Refresh period over all rows, longest time, rounded down per row
    localparam int T_REF_PERIOD_NS = 16000000;
    localparam int REF_ROWS = 1024;
    localparam int REF_INTERVAL_CYC = T_REF_PERIOD_NS / REF_ROWS / CLK_NS;
    // Self refresh period kept by the device itself, in ms
    localparam int T_SELF_REF_MS = 128;
    // Longest row strobe low time in page mode, rounded down
    localparam int T_RASP_MAX_NS = 100000;
    localparam int RAS_MAX_CYC = T_RASP_MAX_NS / CLK_NS;
    // Least page cycle and strobe-first setup, rounded up
    localparam int T_PC_NS = 20;
    localparam int T_CSR_NS = 5;
    localparam int CSR_CYC = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
    // Widths
    localparam int ROW_W = 10;
    localparam int COL_W = 10;
    localparam int ADDR_W = ROW_W + COL_W;
    localparam int DQ_W = 16;
    localparam int LANE_W = 8;
    // Bound on refresh service latency, in cycles
    localparam int REF_SERVICE_MAX = 40;

    // Pins driven toward the DRAM, all strobes active low
    typedef struct packed {
        logic ras_n;
        logic lower_byte_column_strobe_n;
        logic upper_byte_column_strobe_n;
        logic we_n;
        logic oe_n;
        logic [ROW_W-1:0] addr;
    } edc_pins_t;

    localparam edc_pins_t PINS_IDLE = {5'h1f, 10'h000};

    typedef enum logic [3:0] {
        ST_POWER_WAIT = 4'h0,
        ST_IDLE = 4'h1,
        ST_ROW = 4'h2,
        ST_COL = 4'h3,
        ST_RD_A = 4'h4,
        ST_RD_B = 4'h5,
        ST_PRE = 4'h6,
        ST_REF_CAS = 4'h7,
        ST_REF_RAS = 4'h8,
        ST_REF_PRE = 4'h9
    } edc_state_t;
endpackage

/* File: core/edc_sync2.sv */
// Two-stage synchroniser for a bus of pin inputs.
// Assumes the bits are only read as a group once settled.
`timescale 1ns/1ps
module edc_sync2 #(
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    if (W < 1) begin : g_chk
        $error("edc_sync2: width must be positive");
    end

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

/* File: core/edc_refresh_sched.sv */
// Refresh interval timer: raises due once per row interval and flags overrun
// when a second interval expires before the first was served.
// Assumes ack and wake_start are one-cycle pulses from the same clock.
`timescale 1ns/1ps
module edc_refresh_sched #(
    parameter int INTERVAL = 312
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic ack,
    input wire logic wake_start,
    output logic due,
    output logic overrun
);
    localparam int CW = $clog2(INTERVAL + 1);
    localparam logic [CW-1:0] LAST = CW'(INTERVAL - 1);
    logic [CW-1:0] cnt_q;
    logic tick;

    if (INTERVAL < 2) begin : g_chk
        $error("edc_refresh_sched: interval too short");
    end

    assign tick = enable && (cnt_q == LAST);

    // Interval counter
    always_ff @(posedge sys_clk) begin
        if (rst || !enable || tick) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Due flag; a new tick wins over the acknowledge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            due <= 1'b0;
        end else if (tick) begin
            due <= 1'b1;
        end else if (ack) begin
            due <= 1'b0;
        end
    end

    // Overrun flag; set wins over the clear from a wake start
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overrun <= 1'b0;
        end else if (tick && due && !ack) begin
            overrun <= 1'b1;
        end else if (wake_start) begin
            overrun <= 1'b0;
        end
    end
endmodule

/* File: core/edc_host.sv */
// Host controller for a 1M x 16 EDO DRAM: power-up wake, single-word
// accesses with byte lanes, and strobe-first refresh.
// Assumes sys_clk at 20 MHz, data pins resolved by the surrounding wiring.
//
// Function
// - Wait 200 us, then eight wake refreshes
// - Repeat wake sequence after a missed refresh
// - 1024 refreshes within every 16 ms
// - Pulse both strobes high between cycles
// - Write enable low before column strobe: early write
// - Undefined write timing leaves data pins unknown
// - Output enable high, late write enable: late write
// - Never tie output enable low permanently
// - Write command is write enable falling edge
// - Output enable high during any write
// - Column strobe 5 ns before row: refresh
// - Write enable pulse of 10 ns disables outputs
// - Row strobe low at most 100K ns
// - Hidden refresh needs output enable already low
`timescale 1ns/1ps
module edc_host
    import edc_pkg::*;
#(
    parameter int POWER_WAIT = POWER_CYC,
    parameter int REF_INTERVAL = REF_INTERVAL_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DQ_W-1:0] req_wdata,
    input wire logic [1:0] req_be,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DQ_W-1:0] rsp_rdata,
    output logic init_done,
    output edc_pins_t dram_pins,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DQ_W-1:0] dq_in
);
    localparam int PW_W = 13;
    localparam int SERVICE_MAX = REF_SERVICE_MAX;

    edc_state_t state_q, state_d;
    edc_pins_t pins_d;
    logic [PW_W-1:0] wait_q;
    logic [3:0] wake_q;
    logic wr_q;
    logic [1:0] be_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DQ_W-1:0] wdata_q;
    logic [DQ_W-1:0] dq_sync;
    logic due, overrun, take, ref_ack, wake_start, dq_oe_d;

    if (POWER_WAIT < 1 || POWER_WAIT > 8191 || REF_INTERVAL < 2) begin : g_chk
        $error("edc_host: timing parameter out of range");
    end

    // Read data crosses in from the pins through two flops
    edc_sync2 #(.W(DQ_W)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din(dq_in),
        .dout(dq_sync)
    );

    // Row refresh pacing, 1024 rows per period
    edc_refresh_sched #(.INTERVAL(REF_INTERVAL)) u_ref (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(init_done),
        .ack(ref_ack),
        .wake_start(wake_start),
        .due(due),
        .overrun(overrun)
    );

    assign take = (state_q == ST_IDLE) && req_valid && req_ready;
    assign ref_ack = (state_q == ST_REF_PRE) && (wake_q == 4'h0);
    assign wake_start = (state_q == ST_IDLE) && !take && overrun;

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_POWER_WAIT: begin
                if (wait_q == PW_W'(POWER_WAIT - 1)) begin
                    state_d = ST_REF_CAS;
                end
            end
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_ROW;
                end else if (due || overrun) begin
                    state_d = ST_REF_CAS;
                end
            end
            ST_ROW: state_d = ST_COL;
            ST_COL: state_d = wr_q ? ST_PRE : ST_RD_A;
            ST_RD_A: state_d = ST_RD_B;
            ST_RD_B: state_d = ST_PRE;
            ST_PRE: state_d = ST_IDLE;
            ST_REF_CAS: state_d = ST_REF_RAS;
            ST_REF_RAS: state_d = ST_REF_PRE;
            ST_REF_PRE: state_d = (wake_q != 4'h0) ? ST_REF_CAS : ST_IDLE;
            default: state_d = ST_POWER_WAIT;
        endcase
    end

    // Pin values for the coming state
    always_comb begin
        pins_d = PINS_IDLE;
        dq_oe_d = 1'b0;
        case (state_d)
            ST_ROW: begin
                // Entered only on a take, so the request itself is still on the inputs
                pins_d.ras_n = 1'b0;
                pins_d.addr = req_addr[ADDR_W-1:COL_W];
                pins_d.we_n = !req_write;
                dq_oe_d = req_write;
            end
            ST_COL, ST_RD_A, ST_RD_B: begin
                pins_d.ras_n = 1'b0;
                pins_d.addr = addr_q[COL_W-1:0];
                pins_d.lower_byte_column_strobe_n = !be_q[0];
                pins_d.upper_byte_column_strobe_n = !be_q[1];
                pins_d.we_n = !wr_q;
                // Write enable always leads the strobe; no late write is issued
                pins_d.oe_n = wr_q;
                dq_oe_d = wr_q;
            end
            ST_REF_CAS: begin
                // Refresh starts from idle, the power-up pause or a previous wake refresh, with output enable high, never hidden
                pins_d.lower_byte_column_strobe_n = 1'b0;
                pins_d.upper_byte_column_strobe_n = 1'b0;
            end
            ST_REF_RAS: begin
                pins_d.ras_n = 1'b0;
                pins_d.lower_byte_column_strobe_n = 1'b0;
                pins_d.upper_byte_column_strobe_n = 1'b0;
            end
            default: begin
                pins_d = PINS_IDLE;
                dq_oe_d = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_POWER_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Pin registers, all strobes high at reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dram_pins <= PINS_IDLE;
            dq_oe <= 1'b0;
        end else begin
            dram_pins <= pins_d;
            dq_oe <= dq_oe_d;
        end
    end

    // Write data driven toward the pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dq_out <= '0;
        end else if (take) begin
            dq_out <= req_wdata;
        end
    end

    // Power-up pause counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wait_q <= '0;
        end else if (state_q == ST_POWER_WAIT) begin
            wait_q <= wait_q + 1'b1;
        end
    end

    // Wake refresh count: eight at power-up and after an overrun
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wake_q <= 4'h0;
        end else if ((state_q == ST_POWER_WAIT && state_d == ST_REF_CAS) || wake_start) begin
            wake_q <= 4'(WAKE_CYCLES - 1);
        end else if (state_q == ST_REF_PRE && wake_q != 4'h0) begin
            wake_q <= wake_q - 1'b1;
        end
    end

    // Init done once the first wake sequence ends
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            init_done <= 1'b0;
        end else if (ref_ack) begin
            init_done <= 1'b1;
        end
    end

    // Request capture
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_q <= 1'b0;
            be_q <= 2'h0;
            addr_q <= '0;
        end else if (take) begin
            wr_q <= req_write;
            be_q <= req_be;
            addr_q <= req_addr;
        end
    end

    // Ready only while the next state is idle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_d == ST_IDLE) && !take;
        end
    end

    // Response pulse and read data, captured while strobes are still low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= (state_q == ST_RD_B) || (state_q == ST_COL && wr_q);
            if (state_q == ST_RD_B) begin
                rsp_rdata <= dq_sync;
            end
        end
    end

    // Strobe-first refresh: lower column strobe low one cycle before row strobe
    sequence s_cbr;
        !dram_pins.lower_byte_column_strobe_n && dram_pins.ras_n
        ##1 !dram_pins.lower_byte_column_strobe_n && !dram_pins.ras_n;
    endsequence

    // Refresh completes with both strobes high again
    sequence s_ref_end;
        dram_pins.ras_n && dram_pins.lower_byte_column_strobe_n;
    endsequence

    a_pause_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == ST_POWER_WAIT) |-> dram_pins.ras_n && wait_q < PW_W'(POWER_WAIT))
        else $error("row strobe moved during power-up pause");

    a_wake_repeat: assert property (@(posedge sys_clk) disable iff (rst)
        wake_start |=> (state_q == ST_REF_CAS) && (wake_q == 4'(WAKE_CYCLES - 1)))
        else $error("wake sequence not restarted");

    a_cbr_order: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == ST_REF_CAS) |-> s_cbr ##1 s_ref_end)
        else $error("strobe-first refresh order broken");

    a_refresh_served: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(due) |-> ##[1:SERVICE_MAX] ref_ack)
        else $error("refresh not served in time");

    a_early_write: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(dram_pins.lower_byte_column_strobe_n) && wr_q && dram_pins.ras_n == 1'b0)
        |-> $past(!dram_pins.we_n) && dram_pins.oe_n && dq_oe)
        else $error("write enable not ahead of column strobe");

    a_oe_write_high: assert property (@(posedge sys_clk) disable iff (rst)
        !dram_pins.we_n |-> dram_pins.oe_n)
        else $error("output enable low during write");

    a_strobe_precharge: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(dram_pins.ras_n) |-> dram_pins.lower_byte_column_strobe_n
        && dram_pins.upper_byte_column_strobe_n ##1 dram_pins.ras_n)
        else $error("strobes not high together");

    a_bus_float: assert property (@(posedge sys_clk) disable iff (rst)
        (dram_pins.ras_n && dram_pins.lower_byte_column_strobe_n
        && dram_pins.upper_byte_column_strobe_n) |-> !dq_oe)
        else $error("data driven with all strobes high");

    a_ras_bounded: assert property (@(posedge sys_clk) disable iff (rst)
        not (!dram_pins.ras_n [*6]))
        else $error("row strobe held low too long");

    a_lane_select: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == ST_COL) |-> dram_pins.lower_byte_column_strobe_n == !be_q[0]
        && dram_pins.upper_byte_column_strobe_n == !be_q[1])
        else $error("byte lane strobe mismatch");
endmodule

/* File: testbench/edc_dram_model.sv */
// Behavioural EDO DRAM seen from its pins: row/column latch, lanes, refresh count.
// Assumes the data bus is resolved outside and fed back on dq.
`timescale 1ns/1ps
module edc_dram_model
    import edc_pkg::*;
(
    input wire edc_pins_t pins,
    input wire logic [DQ_W-1:0] dq,
    output logic [DQ_W-1:0] dev_dq,
    output logic [1:0] dev_en,
    output int n_refresh,
    output int ras_max_ns
);
    logic [DQ_W-1:0] mem [bit [ADDR_W-1:0]];
    edc_pins_t prev = PINS_IDLE;
    logic [ROW_W-1:0] row = 10'h000;
    logic [COL_W-1:0] col = 10'h000;
    logic refr = 1'b0;
    logic [DQ_W-1:0] word = 16'h0000;
    realtime t_fall = 0;
    logic lo_n;
    logic up_n;
    logic rd_open;

    // Read drive only in an open read cycle, lane by lane
    assign lo_n = pins.lower_byte_column_strobe_n;
    assign up_n = pins.upper_byte_column_strobe_n;
    assign rd_open = !pins.ras_n && !refr && !pins.oe_n && pins.we_n;
    assign dev_en = {rd_open && !up_n, rd_open && !lo_n};
    assign dev_dq = word;

    initial begin
        n_refresh = 0;
        ras_max_ns = 0;
    end

    // Decode strobe edges on every pin change
    always @(pins) begin
        if (prev.ras_n && !pins.ras_n) begin
            t_fall = $realtime;
            if (!prev.lower_byte_column_strobe_n || !prev.upper_byte_column_strobe_n) begin
                n_refresh++;
                refr = 1'b1;
            end else begin
                row = pins.addr;
            end
        end
        if (!prev.ras_n && pins.ras_n) begin
            if (int'($realtime - t_fall) > ras_max_ns) ras_max_ns = int'($realtime - t_fall);
            refr = 1'b0;
        end
        if (!pins.ras_n && !refr) begin
            if (prev.lower_byte_column_strobe_n && prev.upper_byte_column_strobe_n
                && (!lo_n || !up_n)) begin
                col = pins.addr;
                word = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
            end
            // Store only on a column strobe fall, never at the row strobe edge alone
            if (!pins.we_n && (prev.lower_byte_column_strobe_n && !lo_n
                || prev.upper_byte_column_strobe_n && !up_n)) begin
                if (prev.lower_byte_column_strobe_n && !lo_n) word[7:0] = dq[7:0];
                if (prev.upper_byte_column_strobe_n && !up_n) word[15:8] = dq[15:8];
                mem[{row, col}] = word;
            end
        end
        prev = pins;
    end
endmodule

/* File: testbench/test_edo_dram_cycle_protocol.sv */
// Self-checking bench for the EDO DRAM host controller.
// Assumes the DRAM model on the pins; short power and refresh counts.
`timescale 1ns/1ps
module test_edo_dram_cycle_protocol;
    import edc_pkg::*;
    localparam int PW = 20;
    localparam int RI = 40;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = 20'h00000;
    logic [DQ_W-1:0] req_wdata = 16'h0000;
    logic [1:0] req_be = 2'h0;
    logic req_ready;
    logic rsp_valid;
    logic [DQ_W-1:0] rsp_rdata;
    logic init_done;
    edc_pins_t dram_pins;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe;
    logic [DQ_W-1:0] dq_in;
    logic [DQ_W-1:0] dev_dq;
    logic [1:0] dev_en;
    logic [7:0] float_q = 8'h55;
    logic [15:0] rd;
    int n_refresh;
    int ras_max_ns;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;

    edc_host #(.POWER_WAIT(PW), .REF_INTERVAL(RI)) dut (
        .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .init_done(init_done), .dram_pins(dram_pins), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in)
    );

    edc_dram_model mem_model (
        .pins(dram_pins), .dq(dq_in), .dev_dq(dev_dq), .dev_en(dev_en),
        .n_refresh(n_refresh), .ras_max_ns(ras_max_ns)
    );

    // Resolved bus; an undriven lane shows a pattern that flips every cycle
    assign dq_in[7:0] = dq_oe ? dq_out[7:0] : (dev_en[0] ? dev_dq[7:0] : float_q);
    assign dq_in[15:8] = dq_oe ? dq_out[15:8] : (dev_en[1] ? dev_dq[15:8] : ~float_q);

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // Float pattern, conflict watch and hang limit
    always @(posedge sys_clk) begin
        float_q <= ~float_q;
        cyc <= cyc + 1;
        if (dq_oe === 1'b1) check("bus_conflict", 0, dev_en);
        if (cyc == 6000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // One user request, held until taken, then timed to its answer
    task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
                          input logic [1:0] be, output logic [15:0] q);
        int k;
        logic [2:0] hi;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_be = be;
        k = 0;
        while (req_ready !== 1'b1 && k < 200) begin
            @(negedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        k = 1;
        while (rsp_valid !== 1'b1 && k < 20) begin
            @(negedge sys_clk);
            k++;
        end
        check(wr ? "write_latency" : "read_latency", wr ? 3 : 5, k);
        hi = {dram_pins.ras_n, dram_pins.lower_byte_column_strobe_n,
              dram_pins.upper_byte_column_strobe_n};
        check("strobes_high", 3'h7, hi);
        q = rsp_rdata;
    endtask

    task automatic t_init();
        int k;
        k = 0;
        while (init_done !== 1'b1 && k < PW + 100) begin
            @(negedge sys_clk);
            k++;
            if (k == PW - 2) check("refresh_before_pause", 0, n_refresh);
        end
        check("wake_refreshes", 8, n_refresh);
        check("init_time_ok", 1, k >= PW + 22 && k <= PW + 28);
        check("ready_at_init", 1, req_ready);
    endtask

    task automatic t_word();
        access(1'b1, 20'h96a5c, 16'hbeef, 2'h3, rd);
        access(1'b1, 20'h15a5c, 16'h1234, 2'h3, rd);
        access(1'b0, 20'h96a5c, 16'h0000, 2'h3, rd);
        check("read_row_a", 16'hbeef, rd);
        access(1'b0, 20'h15a5c, 16'h0000, 2'h3, rd);
        check("read_row_b", 16'h1234, rd);
    endtask

    task automatic t_lanes();
        access(1'b1, 20'h3ff01, 16'h1122, 2'h3, rd);
        access(1'b1, 20'h3ff01, 16'haabb, 2'h1, rd);
        access(1'b1, 20'h3ff01, 16'hccdd, 2'h2, rd);
        access(1'b0, 20'h3ff01, 16'h0000, 2'h3, rd);
        check("merged_lanes", 16'hccbb, rd);
        access(1'b0, 20'h3ff01, 16'h0000, 2'h1, rd);
        check("lower_lane_read", 8'hbb, rd[7:0]);
    endtask

    task automatic t_refresh();
        int base;
        base = n_refresh;
        repeat (10 * RI) @(negedge sys_clk);
        check("refresh_rate_ok", 1, n_refresh - base >= 9 && n_refresh - base <= 11);
        check("ras_low_ok", 1, ras_max_ns <= T_RASP_MAX_NS);
    endtask

    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        t_init();
        t_word();
        t_lanes();
        t_refresh();
        t_word();
        print_verdict();
    end
endmodule
